// >>> verilog/fpc_top.sv
// flyback pulse control core: valley selection, burst, jitter, protections
`timescale 1ns/100ps
`default_nettype none
module fpc_top #(
  parameter int MAX_OFF_CYCLES = fpc_pkg::MAX_OFF_CYC,
  parameter int OVP_BLANK_CYCLES = fpc_pkg::OVP_BLANK_CYC,
  parameter int HALF_CYCLE_CYCLES = fpc_pkg::HALF_CYCLE_CYC,
  parameter int WAKE_CYCLES = fpc_pkg::WAKE_DEFAULT_CYC,
  parameter int JITTER_CYCLES = fpc_pkg::JITTER_DEFAULT_CYC,
  parameter int RESTART_CYCLES = fpc_pkg::RESTART_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fpc_pkg::fpc_apb_req_type i_apb,
  output fpc_pkg::fpc_apb_rsp_type o_apb,
  input wire logic [fpc_pkg::LOAD_W-1:0] i_load_sense_input,
  input wire logic [fpc_pkg::VALLEY_W-1:0] i_mapped_valley,
  input wire logic [fpc_pkg::DUTY_W-1:0] i_mapped_duty,
  input wire logic [fpc_pkg::ONT_W-1:0] i_mapped_ontime,
  input wire logic i_valley_detect_input,
  input wire logic i_line_sync,
  input wire logic i_line_sense_dc,
  input wire logic i_cs_above_limit,
  input wire logic i_cs_above_severe,
  input wire logic i_demag,
  input wire logic i_supply_on_level,
  input wire logic i_supply_below_off,
  input wire logic i_supply_wake_level,
  input wire logic i_supply_burst_stop_level,
  input wire logic i_supply_overvoltage_level,
  output logic o_gate_drive_output,
  output logic o_startup_control_output,
  output logic [fpc_pkg::LOAD_W-1:0] o_jittered_load,
  output logic [fpc_pkg::VALLEY_W-1:0] o_valley_count,
  output logic o_burst_mode
);
  import fpc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic logic [CNT_W-1:0] to_cnt(input int v);
    to_cnt = v[CNT_W-1:0];
  endfunction : to_cnt

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [ONT_W-1:0] ontime_q;
  logic [3:0] fault_q;
  logic [3:0] fault_set;
  fpc_apb_rsp_type rsp_q;
  logic active_q;
  logic burst_q;
  logic synced_q;
  logic vcc_burst_q;
  logic halt_q;
  logic [VALLEY_W-1:0] valley_q;
  fpc_gate_state_type state_q;
  logic access;
  logic wr;
  logic [31:0] rd_data;
  logic addr_ok;

  assign access = i_apb.psel & i_apb.penable & rsp_q.pready;
  assign wr = access & i_apb.pwrite;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_apb.paddr)
      REG_CTRL: rd_data[1:0] = ctrl_q;
      REG_STATUS: rd_data = {19'h0, valley_q, halt_q, vcc_burst_q,
        synced_q, burst_q, active_q, o_gate_drive_output, state_q};
      REG_FAULT: rd_data[3:0] = fault_q;
      REG_ONTIME: rd_data[ONT_W-1:0] = ontime_q;
      default: addr_ok = 1'b0;
    endcase
  end

  // answer in the access phase right after setup, never a wait state
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rsp_q <= '0;
    else if (i_apb.psel & ~i_apb.penable)
    begin
      rsp_q.pready <= 1'b1;
      rsp_q.pslverr <= ~addr_ok;
      rsp_q.prdata <= i_apb.pwrite ? 32'h0000_0000 : rd_data;
    end
    else
      rsp_q <= '0;
  end
  assign o_apb = rsp_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RESET;
      ontime_q <= ONTIME_RESET;
    end
    else if (wr & (i_apb.paddr == REG_CTRL))
      ctrl_q <= i_apb.pwdata[1:0];
    else if (wr & (i_apb.paddr == REG_ONTIME))
      ontime_q <= i_apb.pwdata[ONT_W-1:0];
  end

  // sticky faults: write one to clear, a new event wins over the clear
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      fault_q <= 4'h0;
    else if (wr & (i_apb.paddr == REG_FAULT))
      fault_q <= (fault_q & ~i_apb.pwdata[3:0]) | fault_set;
    else
      fault_q <= fault_q | fault_set;
  end

  // ----------------------------------------------------------------
  // supply lockout, supply overvoltage, restart hold-off
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] restart_cnt_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      active_q <= 1'b0;
    else if (i_supply_below_off)
      active_q <= 1'b0;
    else if (i_supply_on_level)
      active_q <= 1'b1;
  end

  // restart-class faults stop switching for a fixed hold-off
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      halt_q <= 1'b0;
      restart_cnt_q <= '0;
    end
    else if (fault_set[FLT_SEVERE_CURRENT_FAULT] | fault_set[FLT_SUPOV] | fault_set[FLT_OVP])
    begin
      halt_q <= 1'b1;
      restart_cnt_q <= '0;
    end
    else if (halt_q)
    begin
      restart_cnt_q <= sat_inc(restart_cnt_q);
      if (restart_cnt_q >= to_cnt(RESTART_CYCLES - 1))
        halt_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // half-cycle timing, line sync, wake and jitter periods
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] hc_cnt_q;
  logic [CNT_W-1:0] hc_period_q;
  logic [CNT_W-1:0] jit_period_q;
  logic hc_tick;

  // without a sync the last period (10 ms after reset) paces updates
  assign hc_tick = i_line_sync | (hc_cnt_q >= hc_period_q - 1'b1);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hc_cnt_q <= '0;
      hc_period_q <= to_cnt(HALF_CYCLE_CYCLES);
      jit_period_q <= to_cnt(JITTER_CYCLES);
      synced_q <= 1'b0;
    end
    else
    begin
      hc_cnt_q <= hc_tick ? '0 : sat_inc(hc_cnt_q);
      if (i_line_sync)
      begin
        synced_q <= 1'b1;
        hc_period_q <= sat_inc(hc_cnt_q);
        jit_period_q <= CNT_W'((sat_inc(hc_cnt_q) * JITTER_NUM)
          / JITTER_DEN);
      end
    end
  end

  // ----------------------------------------------------------------
  // dc input triangular jitter on the load current
  // ----------------------------------------------------------------
  localparam logic [LOAD_W-1:0] TRI_MAX = LOAD_W'((1 << JITTER_AMP_LOG2) - 1);
  logic [CNT_W-1:0] tri_cnt_q;
  logic [LOAD_W-1:0] tri_q;
  logic tri_up_q;
  logic [LOAD_W:0] load_sum;

  // one period holds 2^(amp+1)-2 steps of the ramp, 0 up to 2^amp-1 and back
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tri_cnt_q <= '0;
      tri_q <= '0;
      tri_up_q <= 1'b1;
    end
    else if (~(i_line_sense_dc & ctrl_q[CTRL_JIT_BIT]))
    begin
      tri_cnt_q <= '0;
      tri_q <= '0;
      tri_up_q <= 1'b1;
    end
    else if (tri_cnt_q >= (jit_period_q >> (JITTER_AMP_LOG2 + 1)))
    begin
      tri_cnt_q <= '0;
      if (tri_up_q)
      begin
        tri_q <= tri_q + 1'b1;
        tri_up_q <= (tri_q + 1'b1) != TRI_MAX;
      end
      else
      begin
        tri_q <= tri_q - 1'b1;
        tri_up_q <= (tri_q - 1'b1) == '0;
      end
    end
    else
      tri_cnt_q <= sat_inc(tri_cnt_q);
  end

  // clamp the perturbed current so the mapper never sees a wrap
  assign load_sum = {1'b0, i_load_sense_input} + {1'b0, tri_q};

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_jittered_load <= '0;
    else
      o_jittered_load <= load_sum[LOAD_W] ? '1 : load_sum[LOAD_W-1:0];
  end

  // ----------------------------------------------------------------
  // mode and valley selection
  // ----------------------------------------------------------------
  logic [VALLEY_W-1:0] hc_min_q;
  logic [VALLEY_W:0] jump_limit;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      burst_q <= 1'b0;
    else
      burst_q <= i_load_sense_input >= BURST_ENTRY_CURRENT;
  end

  assign jump_limit = {1'b0, valley_q} + {1'b0, VALLEY_JUMP_IMMEDIATE};

  logic wake_tick;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      valley_q <= 5'h01;
      hc_min_q <= '1;
    end
    else if (burst_q)
    begin
      hc_min_q <= '1;
      if (wake_tick)
        valley_q <= i_mapped_valley;
    end
    else if (hc_tick)
    begin
      // the mapped value of this edge counts in the closing half cycle
      valley_q <= (i_mapped_valley < hc_min_q) ? i_mapped_valley
        : hc_min_q;
      hc_min_q <= '1;
    end
    else
    begin
      if (i_mapped_valley < hc_min_q)
        hc_min_q <= i_mapped_valley;
      if (i_mapped_valley < valley_q)
        valley_q <= i_mapped_valley;
      else if ({1'b0, i_mapped_valley} >= jump_limit)
        valley_q <= i_mapped_valley;
    end
  end

  // ----------------------------------------------------------------
  // burst scheduling
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wake_cnt_q;
  logic [CNT_W-1:0] wake_period;
  logic [CNT_W-1:0] burst_len_q;
  logic burst_run_q;
  logic [CNT_W+DUTY_W-1:0] duty_prod;

  // four wakes per line period is two per synced half cycle
  assign wake_period = synced_q ? (hc_period_q >> 1)
    : to_cnt(WAKE_CYCLES);
  assign wake_tick = burst_q & (wake_cnt_q >= wake_period - 1'b1);
  assign duty_prod = wake_period * i_mapped_duty;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wake_cnt_q <= '0;
      burst_len_q <= '0;
      burst_run_q <= 1'b0;
      vcc_burst_q <= 1'b0;
    end
    else if (~burst_q)
    begin
      wake_cnt_q <= '0;
      burst_len_q <= '0;
      burst_run_q <= 1'b0;
      vcc_burst_q <= 1'b0;
    end
    else if (vcc_burst_q)
    begin
      wake_cnt_q <= '0;
      burst_run_q <= 1'b1;
      if (i_supply_burst_stop_level)
      begin
        vcc_burst_q <= 1'b0;
        burst_run_q <= 1'b0;
      end
    end
    else if (i_supply_wake_level)
    begin
      vcc_burst_q <= 1'b1;
      burst_run_q <= 1'b1;
      wake_cnt_q <= '0;
    end
    else if (wake_tick)
    begin
      wake_cnt_q <= '0;
      burst_len_q <= duty_prod[CNT_W+DUTY_W-1:DUTY_W];
      burst_run_q <= (i_load_sense_input < BURST_SKIP_CURRENT)
        & (duty_prod[CNT_W+DUTY_W-1:DUTY_W] != '0);
    end
    else
    begin
      wake_cnt_q <= sat_inc(wake_cnt_q);
      if (wake_cnt_q >= burst_len_q)
        burst_run_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_startup_control_output <= 1'b1;
    else
      o_startup_control_output <= ~((vcc_burst_q & ~i_supply_burst_stop_level)
        | (burst_q & i_supply_wake_level));
  end

  // ----------------------------------------------------------------
  // gate pulse generation and current checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] on_cnt_q;
  logic [CNT_W-1:0] off_cnt_q;
  logic [CNT_W-1:0] lim_cnt_q;
  logic [CNT_W-1:0] ovp_cnt_q;
  logic [VALLEY_W-1:0] seen_q;
  logic [ONT_W-1:0] ontime;
  logic allow;
  logic cycle_current_limit_trip;
  logic on_done;
  logic off_done;

  assign allow = active_q & ~halt_q & ctrl_q[CTRL_EN_BIT]
    & (~burst_q | burst_run_q);
  // on-time tracks the load while the valley stays put, capped by software
  assign ontime = (i_mapped_ontime < ontime_q) ? i_mapped_ontime
    : ontime_q;
  assign cycle_current_limit_trip = i_cs_above_limit & (lim_cnt_q >= to_cnt(LEB_CYC));
  assign on_done = cycle_current_limit_trip | ~allow
    | (on_cnt_q + 1'b1 >= {{(CNT_W-ONT_W){1'b0}}, ontime});
  assign off_done = (i_valley_detect_input
    & ((seen_q + 1'b1) >= ((valley_q == '0) ? 5'h01 : valley_q)))
    | (off_cnt_q >= to_cnt(MAX_OFF_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= GATE_IDLE;
      on_cnt_q <= '0;
      off_cnt_q <= '0;
      seen_q <= '0;
    end
    else
    begin
      case (state_q)
        GATE_IDLE:
          if (allow)
          begin
            state_q <= GATE_ON;
            on_cnt_q <= '0;
          end
        GATE_ON:
          if (on_done)
          begin
            state_q <= GATE_OFF;
            off_cnt_q <= '0;
            seen_q <= '0;
          end
          else
            on_cnt_q <= sat_inc(on_cnt_q);
        GATE_OFF:
          if (off_done)
          begin
            state_q <= allow ? GATE_ON : GATE_IDLE;
            on_cnt_q <= '0;
          end
          else
          begin
            off_cnt_q <= sat_inc(off_cnt_q);
            if (i_valley_detect_input)
              seen_q <= seen_q + 1'b1;
          end
        default:
          state_q <= GATE_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_gate_drive_output <= 1'b0;
    else
      o_gate_drive_output <= (state_q == GATE_ON) & ~on_done
        | (state_q != GATE_ON) & 1'b0
        | (state_q == GATE_IDLE) & allow
        | (state_q == GATE_OFF) & off_done & allow;
  end

  // blanking and window timers, each a cycle counter on a flag
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lim_cnt_q <= '0;
      ovp_cnt_q <= '0;
    end
    else
    begin
      lim_cnt_q <= (o_gate_drive_output & i_cs_above_limit)
        ? sat_inc(lim_cnt_q) : '0;
      ovp_cnt_q <= (i_demag & ~o_gate_drive_output & i_cs_above_limit)
        ? sat_inc(ovp_cnt_q) : '0;
    end
  end

  always_comb
  begin
    fault_set = 4'h0;
    fault_set[FLT_CYCLE_CURRENT_LIMIT] = o_gate_drive_output & cycle_current_limit_trip;
    fault_set[FLT_SEVERE_CURRENT_FAULT] = o_gate_drive_output & i_cs_above_severe
      & (on_cnt_q < to_cnt(SEVERE_WINDOW_CYC));
    fault_set[FLT_SUPOV] = i_supply_overvoltage_level;
    fault_set[FLT_OVP] = ovp_cnt_q >= to_cnt(OVP_BLANK_CYCLES - 1);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_valley_count <= 5'h01;
      o_burst_mode <= 1'b0;
    end
    else
    begin
      o_valley_count <= valley_q;
      o_burst_mode <= burst_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mode_entry: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 burst_q == ($past(i_load_sense_input) >= BURST_ENTRY_CURRENT))
    else $error("mode does not follow load current");

  a_valley_lower: assert property (@(posedge i_clk) disable iff (i_rst)
    (~burst_q & (i_mapped_valley < valley_q))
      |=> valley_q <= $past(i_mapped_valley))
    else $error("lower valley not applied at once");

  a_valley_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (~burst_q & ~hc_tick & (i_mapped_valley > valley_q)
      & ({1'b0, i_mapped_valley} < jump_limit)) |=> $stable(valley_q))
    else $error("small valley rise applied inside half cycle");

  a_off_limit: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == GATE_OFF) |-> off_cnt_q < to_cnt(MAX_OFF_CYCLES))
    else $error("off-time exceeded its limit");

  a_leb_cut: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_gate_drive_output & cycle_current_limit_trip) |=> ~o_gate_drive_output)
    else $error("gate not cut after current limit");

  a_leb_blank: assert property (@(posedge i_clk) disable iff (i_rst)
    fault_set[FLT_CYCLE_CURRENT_LIMIT] |-> $past(i_cs_above_limit, 1) && lim_cnt_q >= 32)
    else $error("current limit tripped inside blanking");

  a_lockout_off: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_below_off |=> ~active_q ##1 ~o_gate_drive_output)
    else $error("lockout did not stop switching");

  a_supply_ov: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_overvoltage_level |=> fault_q[FLT_SUPOV] && halt_q)
    else $error("supply overvoltage not flagged");

  a_wake_pullup: assert property (@(posedge i_clk) disable iff (i_rst)
    (burst_q & i_supply_wake_level) |=> ~o_startup_control_output)
    else $error("start-up pull-up not released on wake");

  a_skip_burst: assert property (@(posedge i_clk) disable iff (i_rst)
    (wake_tick & ~vcc_burst_q & ~i_supply_wake_level
      & (i_load_sense_input >= BURST_SKIP_CURRENT)) |=> ~burst_run_q)
    else $error("burst not skipped at high load");

endmodule : fpc_top
`default_nettype wire

// >>> verilog/fpc_pkg.sv
// constants and bus carrier types for the flyback pulse control core
package fpc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int LEB_TIME_NS = 160;
  localparam int LEB_CYC = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEVERE_WINDOW_NS = 150;
  localparam int SEVERE_WINDOW_CYC = SEVERE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int MAX_OFF_TIME_US = 47;
  localparam int MAX_OFF_CYC = MAX_OFF_TIME_US * CLK_MHZ;
  localparam int OVP_BLANK_US = 100;
  localparam int OVP_BLANK_CYC = OVP_BLANK_US * CLK_MHZ;
  localparam int HALF_CYCLE_DEFAULT_MS = 10;
  localparam int HALF_CYCLE_CYC = HALF_CYCLE_DEFAULT_MS * 1000 * CLK_MHZ;
  localparam int WAKE_DEFAULT_HZ = 200;
  localparam int WAKE_DEFAULT_CYC = CLK_MHZ * 1000000 / WAKE_DEFAULT_HZ;
  localparam int JITTER_DEFAULT_HZ = 222;
  localparam int JITTER_DEFAULT_CYC = CLK_MHZ * 1000000 / JITTER_DEFAULT_HZ;
  // jitter period = line period / 4.44 = half period * 50 / 111
  localparam int JITTER_NUM = 50;
  localparam int JITTER_DEN = 111;
  localparam int RESTART_CYC = 400000;

  // ----------------------------------------------------------------
  // load current (uA) and valley thresholds
  // ----------------------------------------------------------------
  localparam int LOAD_W = 10;
  localparam int VALLEY_W = 5;
  localparam int DUTY_W = 8;
  localparam int ONT_W = 16;
  localparam int CNT_W = 24;
  localparam logic [LOAD_W-1:0] BURST_ENTRY_CURRENT = 10'd560;
  localparam logic [LOAD_W-1:0] BURST_SKIP_CURRENT = 10'd610;
  localparam logic [VALLEY_W-1:0] VALLEY_JUMP_IMMEDIATE = 5'd10;
  localparam int JITTER_AMP_LOG2 = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FAULT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ONTIME = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_JIT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [ONT_W-1:0] ONTIME_RESET = 16'h0FA0;
  localparam int FLT_CYCLE_CURRENT_LIMIT = 0;
  localparam int FLT_SEVERE_CURRENT_FAULT = 1;
  localparam int FLT_SUPOV = 2;
  localparam int FLT_OVP = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } fpc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fpc_apb_rsp_type;

  typedef enum logic [1:0] {
    GATE_IDLE,
    GATE_ON,
    GATE_OFF
  } fpc_gate_state_type;

endpackage : fpc_pkg

// >>> verif/fpc_stage_model.sv
// power stage model: valley pulses and current limit flag
`timescale 1ns/100ps
`default_nettype none
module fpc_stage_model (
  input wire logic i_clk,
  input wire logic i_gate,
  input wire logic i_short,
  input wire logic i_stall,
  input wire logic i_mirror,
  output logic o_valley,
  output logic o_cs
);
  logic g_q = 1'b0;
  logic [2:0] ring_q = 3'h0;
  // ring restarts at each switch edge, one valley per 8 cycles
  always_ff @(posedge i_clk)
  begin
    g_q <= i_gate;
    ring_q <= (i_gate != g_q) ? 3'h0 : ring_q + 3'h1;
  end
  // stall mimics a ring too damped to show any valley
  assign o_valley = !i_gate && !i_stall && ring_q == 3'h7;
  // off phase: sense pin mirrors the reflected output voltage
  assign o_cs = i_gate ? i_short : i_mirror;
endmodule : fpc_stage_model
`default_nettype wire

// >>> verif/fpc_top_tb.sv
// self-checking bench for the flyback pulse control core
`timescale 1ns/100ps
`default_nettype none
module fpc_top_tb;
  import fpc_pkg::*;
  // ----
  // stimulus
  // ----
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  fpc_apb_req_type req = '0;
  fpc_apb_rsp_type rsp;
  logic [LOAD_W-1:0] load = 10'h064;
  logic [LOAD_W-1:0] jl;
  logic [VALLEY_W-1:0] mv = 5'h01;
  logic [VALLEY_W-1:0] vc;
  logic [DUTY_W-1:0] duty = 8'h00;
  logic sync = 1'b0, dc = 1'b0, son = 1'b0, wake = 1'b0, stop = 1'b0;
  logic ovl = 1'b0, shrt = 1'b0, stall = 1'b0;
  logic sev = 1'b0, dmg = 1'b0, boff = 1'b0;
  logic [ONT_W-1:0] ont = 16'h0100;
  logic valley, cs, gate, su, burst, err;
  logic [31:0] rd;
  int c;
  int error_cnt = 0;
  int compares = 0;
  fpc_top #(.MAX_OFF_CYCLES(200), .OVP_BLANK_CYCLES(50),
    .HALF_CYCLE_CYCLES(1000),
    .RESTART_CYCLES(100)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_apb(req), .o_apb(rsp), .i_load_sense_input(load),
    .i_mapped_valley(mv), .i_mapped_duty(duty),
    .i_mapped_ontime(ont), .i_valley_detect_input(valley),
    .i_line_sync(sync), .i_line_sense_dc(dc), .i_cs_above_limit(cs),
    .i_cs_above_severe(sev), .i_demag(dmg), .i_supply_on_level(son),
    .i_supply_below_off(boff), .i_supply_wake_level(wake),
    .i_supply_burst_stop_level(stop), .i_supply_overvoltage_level(ovl),
    .o_gate_drive_output(gate), .o_startup_control_output(su),
    .o_jittered_load(jl), .o_valley_count(vc), .o_burst_mode(burst));
  fpc_stage_model u_stage (.i_clk(i_clk), .i_gate(gate), .i_short(shrt),
    .i_stall(stall), .i_mirror(dmg), .o_valley(valley), .o_cs(cs));
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic give_up(input string w);
    chk(w, 32'h0000_0001, 32'h0000_0000);
    print_verdict();
  endtask : give_up
  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1)
      give_up("apb wait");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge i_clk);
  endtask : apb
  task automatic wait_gate(input logic v, input int lim);
    int n;
    n = 0;
    while (gate !== v)
    begin
      @(posedge i_clk);
      n++;
      if (n > lim)
        give_up("gate wait");
    end
  endtask : wait_gate
  task automatic count_gate(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge i_clk);
      c += int'(gate === 1'b1);
    end
  endtask : count_gate
  task automatic s_regs();
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl", rd, 32'h0000_0001);
    apb(1'b0, REG_ONTIME, '0);
    chk("ontime", rd, 32'h0000_0FA0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk("unmapped", 32'(err), 32'h0000_0001);
    apb(1'b1, REG_ONTIME, 32'h0000_0100);
    tick(20);
    chk("lockout gate", 32'(gate), 32'h0000_0000);
  endtask : s_regs
  task automatic s_limit();
    son <= 1'b1;
    wait_gate(1'b1, 60);
    shrt <= 1'b1;
    wait_gate(1'b0, 40);
    shrt <= 1'b0;
    apb(1'b0, REG_FAULT, '0);
    chk("limit flag", 32'(rd[FLT_CYCLE_CURRENT_LIMIT]), 32'h0000_0001);
    stall <= 1'b1;
    wait_gate(1'b1, 300);
    wait_gate(1'b0, 300);
    tick(150);
    chk("off hold", 32'(gate), 32'h0000_0000);
    wait_gate(1'b1, 70);
    stall <= 1'b0;
  endtask : s_limit
  task automatic s_valley();
    mv <= 5'h0C;
    tick(4);
    chk("rise 11", 32'(vc), 32'h0000_000C);
    mv <= 5'h03;
    tick(4);
    chk("fall", 32'(vc), 32'h0000_0003);
    mv <= 5'h05;
    tick(20);
    chk("rise 2", 32'(vc), 32'h0000_0003);
    repeat (2)
    begin
      sync <= 1'b1;
      tick(1);
      sync <= 1'b0;
      tick(8);
    end
    chk("half min", 32'(vc), 32'h0000_0005);
  endtask : s_valley
  task automatic s_burst();
    load <= 10'h230;
    tick(4);
    chk("burst in", 32'(burst), 32'h0000_0001);
    load <= 10'h258;
    duty <= 8'h80;
    count_gate(1100);
    chk("pulsing", 32'(c > 0), 32'h0000_0001);
    load <= 10'h262;
    tick(600);
    count_gate(1100);
    chk("skip", 32'(c), 32'h0000_0000);
    wake <= 1'b1;
    tick(4);
    chk("pull-up off", 32'(su), 32'h0000_0000);
    wait_gate(1'b1, 300);
    wake <= 1'b0;
    stop <= 1'b1;
    tick(4);
    chk("pull-up on", 32'(su), 32'h0000_0001);
    load <= 10'h22F;
    tick(4);
    chk("burst out", 32'(burst), 32'h0000_0000);
  endtask : s_burst
  task automatic s_misc();
    load <= 10'h12C;
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    dc <= 1'b1;
    c = 0;
    repeat (700)
    begin
      @(posedge i_clk);
      c += int'(jl !== load);
    end
    chk("jitter", 32'(c > 0), 32'h0000_0001);
    dc <= 1'b0;
    tick(4);
    chk("no jitter", 32'(jl), 32'(load));
    ovl <= 1'b1;
    tick(4);
    chk("ov gate", 32'(gate), 32'h0000_0000);
    apb(1'b0, REG_FAULT, '0);
    chk("ov flag", 32'(rd[FLT_SUPOV]), 32'h0000_0001);
  endtask : s_misc
  task automatic s_prot();
    ovl <= 1'b0;
    ont <= 16'h0010;
    wait_gate(1'b1, 200);
    wait_gate(1'b0, 20);
    wait_gate(1'b1, 300);
    sev <= 1'b1;
    tick(4);
    chk("severe gate", 32'(gate), 32'h0000_0000);
    sev <= 1'b0;
    apb(1'b0, REG_FAULT, '0);
    chk("severe flag", 32'(rd[FLT_SEVERE_CURRENT_FAULT]), 32'h0000_0001);
    apb(1'b1, REG_FAULT, 32'h0000_000F);
    apb(1'b0, REG_FAULT, '0);
    chk("fault clear", rd, 32'h0000_0000);
    dmg <= 1'b1;
    tick(60);
    apb(1'b0, REG_FAULT, '0);
    chk("ovp flag", 32'(rd[FLT_OVP]), 32'h0000_0001);
    dmg <= 1'b0;
    boff <= 1'b1;
    tick(2);
    apb(1'b0, REG_STATUS, '0);
    chk("lockout off", 32'(rd[3]), 32'h0000_0000);
    boff <= 1'b0;
  endtask : s_prot
  initial
  begin
    tick(5);
    i_rst <= 1'b0;
    s_regs();
    s_limit();
    s_valley();
    s_burst();
    s_misc();
    s_prot();
    print_verdict();
  end
endmodule : fpc_top_tb
`default_nettype wire
